// *** rtl/adc_serial_readout_chain.v ***
`timescale 1ns/1ps
`include "adc_readout_defs.vh"
module adc_serial_readout_chain #(
  parameter DATA_WIDTH = `ADC_RESULT_BITS,
  parameter FIFO_DEPTH = `ADC_FIFO_DEPTH,
  parameter CONV_MIN_CYCLES = `ADC_CONV_MIN_CYCLES,
  parameter CONV_MAX_CYCLES = `ADC_CONV_MAX_CYCLES,
  parameter CONV_CYCLES = `ADC_CONV_MAX_CYCLES,
  parameter FAR_END = 1
)
(
  input wire clock,
  input wire rst,
  input wire conversionTrigger,
  input wire serialClock,
  input wire serialDataIn,
  input wire [DATA_WIDTH-1:0] sampleData,
  input wire sampleValid,
  output wire sampleReady,
  output reg serialDataOut,
  output reg serialDataOutEn,
  output reg powerDown,
  output reg converting
);

  ////////////////////////////////////////////////////////////////////////////
  // States and derived constants

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_CONV = 6'h02;
  localparam [5:0] ST_WAIT = 6'h04;
  localparam [5:0] ST_SHIFT = 6'h08;
  localparam [5:0] ST_CHAIN = 6'h10;
  localparam [5:0] ST_HOLD = 6'h20;

  // Conversion length is kept inside the documented window
  localparam CONV_LEN = (CONV_CYCLES < CONV_MIN_CYCLES) ? CONV_MIN_CYCLES :
                        (CONV_CYCLES > CONV_MAX_CYCLES) ? CONV_MAX_CYCLES : CONV_CYCLES;
  localparam CNT_BITS = 16;
  localparam [CNT_BITS-1:0] CONV_LAST = CONV_LEN - 1;
  localparam [5:0] BITS_PLAIN = `ADC_RESULT_BITS;
  localparam [5:0] BITS_BUSY = `ADC_BUSY_READ_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  reg cnvMeta;
  reg cnvSync;
  reg cnvLast;
  reg sckMeta;
  reg sckSync;
  reg sckLast;
  reg sdiMeta;
  reg sdiSync;
  reg sdiLast;
  wire cnvRise;
  wire sckFall;
  wire sdiRise;

  always @(posedge clock)
  begin
    if (rst)
    begin
      cnvMeta <= 1'b0;
      cnvSync <= 1'b0;
      cnvLast <= 1'b0;
      sckMeta <= 1'b0;
      sckSync <= 1'b0;
      sckLast <= 1'b0;
      // Data input rests high: resetting low would drive the pin and fake a rise
      sdiMeta <= 1'b1;
      sdiSync <= 1'b1;
      sdiLast <= 1'b1;
    end
    else
    begin
      cnvMeta <= conversionTrigger;
      cnvSync <= cnvMeta;
      cnvLast <= cnvSync;
      sckMeta <= serialClock;
      sckSync <= sckMeta;
      sckLast <= sckSync;
      sdiMeta <= serialDataIn;
      sdiSync <= sdiMeta;
      sdiLast <= sdiSync;
    end
  end

  assign cnvRise = cnvSync && !cnvLast;
  assign sckFall = sckLast && !sckSync;
  assign sdiRise = sdiSync && !sdiLast;

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffer standing in for the converter core

  wire [DATA_WIDTH-1:0] fifoData;
  wire fifoValid;
  wire convDone;

  sample_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .PTR_BITS($clog2(FIFO_DEPTH))
  ) resultBuffer (
    .clock(clock),
    .rst(rst),
    .inData(sampleData),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(convDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode, conversion counter and readout shifter

  reg [5:0] state;
  reg selectMode;
  reg busyEnable;
  reg startPending;
  reg [CNT_BITS-1:0] convCount;
  reg [5:0] bitCount;
  reg [DATA_WIDTH:0] shiftReg;
  wire [DATA_WIDTH-1:0] result;
  wire shiftIn;
  wire [5:0] releaseCount;
  wire busyAtEnd;

  assign convDone = state[1] && (convCount == CONV_LAST);
  assign result = fifoValid ? fifoData : {DATA_WIDTH{1'b0}};
  // chain passes the data input through
  assign shiftIn = selectMode ? 1'b0 : sdiSync;
  assign releaseCount = busyEnable ? BITS_BUSY : BITS_PLAIN;
  assign busyAtEnd = !cnvSync || !sdiSync;

  always @(posedge clock)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      selectMode <= 1'b1;
      busyEnable <= 1'b0;
      startPending <= 1'b0;
      convCount <= {CNT_BITS{1'b0}};
      bitCount <= 6'h00;
      shiftReg <= {(DATA_WIDTH+1){1'b0}};
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (cnvRise)
          begin
            selectMode <= sdiSync;
            // clock low selects chain without busy
            // clock high selects chain with busy
            busyEnable <= !sdiSync && sckSync;
            convCount <= {CNT_BITS{1'b0}};
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          convCount <= convCount + 1'b1;
          if (convDone)
          begin
            bitCount <= 6'h00;
            if (selectMode)
            begin
              busyEnable <= busyAtEnd;
              // low start bit ahead of the data
              if (busyAtEnd)
              begin
                shiftReg <= {1'b0, result};
                startPending <= 1'b1;
                state <= ST_SHIFT;
              end
              else
              begin
                shiftReg <= {result, 1'b0};
                startPending <= 1'b0;
                state <= ST_WAIT;
              end
            end
            else
            begin
              // high start bit in busy chain
              shiftReg <= busyEnable ? {1'b1, result} : {result, 1'b0};
              startPending <= busyEnable;
              state <= ST_CHAIN;
            end
          end
        end
        ST_WAIT:
        begin
          if (!sdiSync)
            state <= ST_SHIFT;
          else if (!cnvSync)
            state <= ST_IDLE;
        end
        ST_SHIFT:
        begin
          // release on the rise as well
          if (sdiRise)
            state <= ST_HOLD;
          else if (sckFall)
          begin
            // falling edge shifts the next bit
            shiftReg <= {shiftReg[DATA_WIDTH-1:0], 1'b0};
            startPending <= 1'b0;
            bitCount <= bitCount + 1'b1;
            if (bitCount + 1'b1 == releaseCount)
              state <= ST_HOLD;
          end
        end
        ST_CHAIN:
        begin
          if (!cnvSync)
            state <= ST_IDLE;
          else if (sckFall)
          begin
            startPending <= 1'b0;
            // data input enters below the output window
            if (startPending)
              shiftReg <= {shiftReg[DATA_WIDTH-1:0], 1'b0};
            else
              shiftReg <= {shiftReg[DATA_WIDTH-1:1], shiftIn, 1'b0};
          end
        end
        ST_HOLD:
        begin
          if (!cnvSync)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin and power state, all registered

  reg next_out;
  reg next_outEn;

  // bit only changes on falling edges, so it holds across the rising edge
  always @*
  begin
    next_out = 1'b0;
    next_outEn = 1'b0;
    case (state)
      ST_SHIFT:
      begin
        next_out = shiftReg[DATA_WIDTH];
        next_outEn = 1'b1;
      end
      ST_CHAIN:
      begin
        // head goes high at once when FAR_END is set, otherwise only once upstream is done too
        if (startPending)
          next_out = (FAR_END != 0) || sdiSync;
        else
          next_out = shiftReg[DATA_WIDTH];
        next_outEn = 1'b1;
      end
      ST_CONV:
      begin
        // released while converting in select mode
        next_outEn = !selectMode;
      end
      default:
      begin
        next_out = 1'b0;
        next_outEn = 1'b0;
      end
    endcase
    // both low drive the line low, outside an active readout
    if (!cnvSync && !sdiSync && !state[3] && !state[4])
    begin
      next_out = 1'b0;
      next_outEn = 1'b1;
    end
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      serialDataOut <= 1'b0;
      serialDataOutEn <= 1'b0;
      powerDown <= 1'b1;
      converting <= 1'b0;
    end
    else
    begin
      serialDataOut <= next_out;
      serialDataOutEn <= next_outEn;
      powerDown <= !(state[1] && !convDone) && !(state[0] && cnvRise);
      converting <= (state[1] && !convDone) || (state[0] && cnvRise);
    end
  end

endmodule

// *** rtl/adc_readout_defs.vh ***
`ifndef ADC_READOUT_DEFS_VH
`define ADC_READOUT_DEFS_VH

// System clock rate and conversion window, times in nanoseconds
`define ADC_CLOCK_MHZ 25
`define ADC_CONV_MIN_NS 500
`define ADC_CONV_MAX_NS 2200

// Least time rounds up, longest time rounds down, never below one cycle
`define ADC_CONV_MIN_RAW ((`ADC_CONV_MIN_NS * `ADC_CLOCK_MHZ + 999) / 1000)
`define ADC_CONV_MAX_RAW ((`ADC_CONV_MAX_NS * `ADC_CLOCK_MHZ) / 1000)
`define ADC_CONV_MIN_CYCLES ((`ADC_CONV_MIN_RAW < 1) ? 1 : `ADC_CONV_MIN_RAW)
`define ADC_CONV_MAX_CYCLES ((`ADC_CONV_MAX_RAW < 1) ? 1 : `ADC_CONV_MAX_RAW)

// Result layout
`define ADC_RESULT_BITS 16
`define ADC_BUSY_READ_BITS 17
`define ADC_FIFO_DEPTH 8

`endif

// *** rtl/sample_fifo.v ***
`timescale 1ns/1ps
module sample_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter PTR_BITS = 3
)
(
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  output wire [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_BITS-1:0] wrPtr;
  reg [PTR_BITS-1:0] rdPtr;
  reg [PTR_BITS:0] count;
  wire doWrite;
  wire doRead;
  reg [PTR_BITS:0] next_count;

  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem[rdPtr];

  always @*
  begin
    next_count = count;
    if (doWrite && !doRead)
      next_count = count + 1'b1;
    else if (doRead && !doWrite)
      next_count = count - 1'b1;
  end

  // Flags are registered so the ready seen by the source never glitches
  always @(posedge clock)
  begin
    if (rst)
    begin
      wrPtr <= {PTR_BITS{1'b0}};
      rdPtr <= {PTR_BITS{1'b0}};
      count <= {(PTR_BITS+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      if (doWrite)
      begin
        mem[wrPtr] <= inData;
        wrPtr <= (wrPtr == DEPTH - 1) ? {PTR_BITS{1'b0}} : wrPtr + 1'b1;
      end
      if (doRead)
        rdPtr <= (rdPtr == DEPTH - 1) ? {PTR_BITS{1'b0}} : rdPtr + 1'b1;
      count <= next_count;
      inReady <= (next_count < DEPTH);
      outValid <= (next_count != {(PTR_BITS+1){1'b0}});
    end
  end

endmodule

// *** tb/adc_readout_asserts.sv ***
`timescale 1ns/1ps
module adc_readout_asserts #(
  parameter CONV_MIN_CYCLES = 13,
  parameter CONV_MAX_CYCLES = 55
)
(
  input wire clock,
  input wire rst,
  input wire conversionTrigger,
  input wire serialClock,
  input wire serialDataIn,
  input wire sampleValid,
  input wire sampleReady,
  input wire serialDataOut,
  input wire serialDataOutEn,
  input wire powerDown,
  input wire converting
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  reg [7:0] convCount;
  reg [3:0] held;
  // Words leave only at conversion end, so held may trail the buffer by one
  always @(posedge clock)
  begin
    if (rst)
    begin
      convCount <= 8'h00;
      held <= 4'h0;
    end
    else
    begin
      convCount <= converting ? convCount + 8'h01 : 8'h00;
      held <= held + (sampleValid & sampleReady) - ($fell(converting) && held != 4'h0);
    end
  end
  ////////////////////////////////////////
  sequence pinsLow;
    (!conversionTrigger && !serialDataIn) [*6];
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> !serialDataOutEn && powerDown)
    else $error("outputs active after reset");
  power_state_a: assert property (powerDown != converting)
    else $error("power down not opposite to converting");
  conv_window_a: assert property ($fell(converting) |->
      convCount >= CONV_MIN_CYCLES && convCount <= CONV_MAX_CYCLES)
    else $error("conversion length outside window");
  trig_start_a: assert property ($rose(conversionTrigger) && !converting |->
      ##[2:6] converting)
    else $error("trigger did not start conversion");
  idle_low_a: assert property (pinsLow |-> serialDataOutEn && !serialDataOut)
    else $error("idle output not driven low");
  bit_hold_a: assert property ($rose(serialClock) && serialDataOutEn |=>
      $stable(serialDataOut) [*3])
    else $error("bit changed around rising clock");
  busy_drive_a: assert property ($fell(converting) && !serialDataIn |->
      ##[0:2] serialDataOutEn)
    else $error("busy output not driven");
  buffer_full_a: assert property (held == 4'h8 && $rose(converting) |-> !sampleReady)
    else $error("full buffer still ready");
endmodule
bind adc_serial_readout_chain adc_readout_asserts #(
  .CONV_MIN_CYCLES(CONV_MIN_CYCLES),
  .CONV_MAX_CYCLES(CONV_MAX_CYCLES)
) checker_inst (
  .clock(clock), .rst(rst), .conversionTrigger(conversionTrigger),
  .serialClock(serialClock), .serialDataIn(serialDataIn), .sampleValid(sampleValid),
  .sampleReady(sampleReady), .serialDataOut(serialDataOut),
  .serialDataOutEn(serialDataOutEn), .powerDown(powerDown), .converting(converting)
);

// *** tb/adc_host_model.sv ***
`timescale 1ns/1ps
module adc_host_model
(
  input wire clock,
  input wire serialDataOut,
  input wire serialDataOutEn,
  output reg conversionTrigger,
  output reg serialClock,
  output reg serialDataIn
);
  reg [32:0] got;
  integer j;
  // Pull-up on the data line, so a released output reads high
  wire pin = serialDataOutEn ? serialDataOut : 1'h1;
  initial
  begin
    conversionTrigger = 1'h0;
    serialClock = 1'h0;
    serialDataIn = 1'h1;
  end
  ////////////////////////////////////////
  // pin levels
  task pins(input t, input c, input d, input integer n);
  begin
    @(posedge clock);
    conversionTrigger <= t;
    serialClock <= c;
    serialDataIn <= d;
    repeat (n - 1) @(posedge clock);
  end
  endtask
  task read(input integer n, input [32:0] din);
  begin
    got = 33'h0;
    for (j = 0; j < n; j = j + 1)
    begin
      @(posedge clock);
      serialDataIn <= din[32 - j];
      serialClock <= 1'h1;
      repeat (2) @(posedge clock);
      got = {got[31:0], pin};
      repeat (2) @(posedge clock);
      serialClock <= 1'h0;
      repeat (3) @(posedge clock);
    end
  end
  endtask
endmodule

// *** tb/adc_serial_readout_chain_test.sv ***
`timescale 1ns/1ps
module adc_serial_readout_chain_test;
  reg clock = 1'h0;
  reg rst = 1'h1;
  reg [15:0] sampleData = 16'h0000;
  reg sampleValid = 1'h0;
  wire sampleReady;
  wire conversionTrigger;
  wire serialClock;
  wire serialDataIn;
  wire serialDataOut;
  wire serialDataOutEn;
  wire powerDown;
  wire converting;
  integer seed = 91;
  integer failCount = 0;
  integer comparisons = 0;
  integer i;
  integer k;
  integer r;
  reg [1:0] mode;
  reg [32:0] din;
  reg [15:0] words [0:8];
  always #20 clock = ~clock;
  adc_serial_readout_chain #(.CONV_CYCLES(20), .FAR_END(1)) dut (
    .clock(clock), .rst(rst), .conversionTrigger(conversionTrigger),
    .serialClock(serialClock), .serialDataIn(serialDataIn), .sampleData(sampleData),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .powerDown(powerDown), .converting(converting)
  );
  adc_host_model host (
    .clock(clock), .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .conversionTrigger(conversionTrigger), .serialClock(serialClock),
    .serialDataIn(serialDataIn)
  );
  ////////////////////////////////////////
  task closeOut;
  begin
    if (failCount == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task check(input [32:0] actual, input [32:0] want);
  begin
    comparisons = comparisons + 1;
    if (actual !== want)
    begin
      failCount = failCount + 1;
      $display("[FAIL] %0t got %h want %h", $time, actual, want);
    end
  end
  endtask
  // Chain modes append the upstream bits that entered behind the result;
  // a busy chain drops the bit present at the start-bit fall
  function [32:0] predictBits(input [1:0] m, input [15:0] w, input [32:0] d);
    predictBits = m[1] ? {m[0], w, m[0] ? d[31:16] : d[32:17]} : {17'h0, w};
  endfunction
  initial
  begin
    for (k = 0; k < 9; k = k + 1)
    begin
      r = $random(seed);
      words[k] = r[15:0];
    end
    words[0] = 16'hffff;
    words[7] = 16'h0001;
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    repeat (4) @(posedge clock);
    k = 0;
    sampleValid <= 1'h1;
    sampleData <= words[0];
    repeat (12)
    begin
      @(posedge clock);
      if (sampleReady === 1'h1)
        k = k + 1;
      sampleData <= words[k];
    end
    sampleValid <= 1'h0;
    check(k, 8);
    check(sampleReady, 1'h0);
    // Mode cycles through all four; the ninth finds the buffer empty
    for (i = 0; i < 9; i = i + 1)
    begin
      mode = i % 4;
      r = $random(seed);
      din = mode[1] ? {r, 1'h0} : 33'h0;
      host.pins(1'h0, mode == 3, mode < 2, 8);
      host.pins(1'h1, mode == 3, mode < 2, 4);
      host.pins(1'h1, mode == 3, mode == 0, 36);
      check({converting, powerDown}, 2'h1);
      if (mode == 0)
      begin
        check(serialDataOutEn, 1'h0);
        host.pins(1'h1, 1'h0, 1'h0, 8);
      end
      if (mode == 1)
        check({serialDataOutEn, serialDataOut}, 2'h2);
      if (mode == 3)
        check({serialDataOutEn, serialDataOut}, 2'h3);
      host.read(16 + mode[0] + 16 * mode[1], din);
      check(host.got, predictBits(mode, i < 8 ? words[i] : 16'h0, din));
      host.pins(1'h1, 1'h0, 1'h0, 4);
      check(serialDataOutEn, mode[1]);
      if (i == 0)
        check(sampleReady, 1'h1);
      host.pins(1'h0, 1'h0, mode != 2, 8);
      if (mode == 2)
        check({serialDataOutEn, serialDataOut}, 2'h2);
      host.pins(1'h0, 1'h0, 1'h1, 8);
    end
    closeOut;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    failCount = failCount + 1;
    closeOut;
  end
endmodule
